// ---- src/flash_config_latency_status.sv ----
// serial register access, protection bits, suspend status and latency
`timescale 1ns/1ps
`default_nettype none
module flash_config_latency_status
  import flash_cfg_pkg::*;
#(
  parameter bit ENHANCED = 1'b0,
  parameter logic [7:0] CONFIG_INIT = CONFIG_RESET,
  parameter logic [2:0] SIZE_INIT = 3'h0
) (
  // clock and power-on reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // serial link pins, asynchronous
  input wire spi_pins_t i_spi,
  output logic o_so,
  output logic o_so_oe,
  // hardware reset, write-protect and hold pins, asynchronous
  input wire logic i_reset_pin_n,
  input wire logic i_wp_n,
  input wire logic i_hold_n,
  // suspend state from the array controller, same clock
  input wire logic i_erase_suspended,
  input wire logic i_program_suspended,
  // register and pin views for the array controller
  output logic [7:0] o_config_one,
  output logic [7:0] o_status_one,
  output logic [7:0] o_suspend_status,
  output logic o_wp_n_eff,
  output logic o_hold_n_eff,
  // counts of the last read command
  output logic [6:0] o_read_latency
);

  // all state of this module
  typedef struct packed {
    spi_pins_t sync1;        // first synchroniser stage
    spi_pins_t sync2;        // second synchroniser stage
    logic sck_d;             // delayed clock for edge finding
    logic cs_n_d;            // delayed select for end of frame
    logic rst_s1;
    logic rst_s2;
    logic wp_s1;
    logic wp_s2;
    logic hold_s1;
    logic hold_s2;
    spi_state_t st;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [1:0] wr_cnt;      // bytes of a register write taken
    logic [7:0] wr_stat;
    logic [7:0] wr_cfg;
    logic [7:0] config_one;
    logic [7:0] status_one;
    logic [7:0] suspend;
    logic so;
    logic so_oe;
    logic wp_eff;
    logic hold_eff;
    read_kind_t kind;
    logic kind_stb;
  } core_t;

  core_t r;
  core_t n;

  // combinational helpers, filled in the single comb process
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic frame_end;
  logic hw_rst;
  logic soft_rst;
  logic clr_perr;
  logic perr_set;
  logic commit;
  logic [7:0] byte_in;

  // read command code to read family
  function automatic read_kind_t kind_of(input logic [7:0] c);
    read_kind_t k;
    case (c)
      8'h03, 8'h13: k = RK_PLAIN;
      8'h0B, 8'h0C: k = RK_FAST;
      8'h3B, 8'h3C: k = RK_DUAL_OUT;
      8'h6B, 8'h6C: k = RK_QUAD_OUT;
      8'hBB, 8'hBC: k = RK_DUAL_IO;
      8'hEB, 8'hEC: k = RK_QUAD_IO;
      8'h0D, 8'h0E: k = RK_DDR_FAST;
      8'hBD, 8'hBE: k = RK_DDR_DUAL;
      8'hED, 8'hEE: k = RK_DDR_QUAD;
      default: k = RK_NONE;
    endcase
    return k;
  endfunction

  // next state of everything
  always_comb begin
    n = r;
    n.kind_stb = 1'b0;
    soft_rst = 1'b0;
    clr_perr = 1'b0;
    perr_set = 1'b0;
    // synchronisers; stage one is read only by stage two
    n.sync1 = i_spi;
    n.sync2 = r.sync1;
    n.sck_d = r.sync2.sck;
    n.cs_n_d = r.sync2.cs_n;
    n.rst_s1 = i_reset_pin_n;
    n.rst_s2 = r.rst_s1;
    n.wp_s1 = i_wp_n;
    n.wp_s2 = r.wp_s1;
    n.hold_s1 = i_hold_n;
    n.hold_s2 = r.hold_s1;
    sck_rise = r.sync2.sck & ~r.sck_d;
    sck_fall = ~r.sync2.sck & r.sck_d;
    cs_act = ~r.sync2.cs_n;
    frame_end = r.sync2.cs_n & ~r.cs_n_d;
    hw_rst = ~r.rst_s2;
    byte_in = {r.shift_in[6:0], r.sync2.si};
    commit = frame_end && (r.st == ST_WRITE) && (r.wr_cnt != 2'h0);

    // serial frame handling
    if (!cs_act) begin
      // deselected: frame over, release the output line
      n.st = ST_CMD;
      n.bit_cnt = 3'h0;
      n.wr_cnt = 2'h0;
      n.so_oe = 1'b0;
    end else if (sck_rise) begin
      n.shift_in = byte_in;
      n.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == BIT_CNT_LAST) begin
        case (r.st)
          ST_CMD: begin
            n.st = ST_IGNORE;
            case (byte_in)
              CMD_WRITE_REGS: begin
                n.st = ST_WRITE;
                n.wr_cnt = 2'h0;
              end
              CMD_READ_STATUS_ONE: begin
                n.st = ST_READ;
                n.shift_out = r.status_one;
              end
              CMD_READ_STATUS_TWO: begin
                n.st = ST_READ;
                n.shift_out = r.suspend;
              end
              CMD_READ_CONFIG: begin
                n.st = ST_READ;
                n.shift_out = r.config_one;
              end
              CMD_CLEAR_STATUS: clr_perr = 1'b1;
              CMD_SOFT_RESET: soft_rst = 1'b1;
              default: begin
                // a read: latch its family for the latency decoder
                n.kind = kind_of(byte_in);
                n.kind_stb = (kind_of(byte_in) != RK_NONE);
              end
            endcase
          end
          ST_WRITE: begin
            if (r.wr_cnt == 2'h0) begin
              n.wr_stat = byte_in;
              n.wr_cnt = WR_ONE_BYTE;
            end else if (r.wr_cnt == WR_ONE_BYTE) begin
              n.wr_cfg = byte_in;
              n.wr_cnt = WR_TWO_BYTES;
            end
          end
          default: n.st = r.st;
        endcase
      end
    end else if (sck_fall && r.st == ST_READ) begin
      // shift out msb first; the byte repeats while selected
      n.so = r.shift_out[7];
      n.so_oe = 1'b1;
      n.shift_out = {r.shift_out[6:0], r.shift_out[7]};
    end

    // register write takes effect when the frame ends
    if (commit) begin
      // size bits locked by freeze
      if (!r.config_one[CFG_FREEZE]) begin
        n.status_one[ST1_SIZE_HI:ST1_SIZE_LO] =
          r.wr_stat[ST1_SIZE_HI:ST1_SIZE_LO];
      end
      if (r.wr_cnt == WR_TWO_BYTES) begin
        n.config_one[CFG_LAT_HI:CFG_LAT_LO] =
          r.wr_cfg[CFG_LAT_HI:CFG_LAT_LO];
        n.config_one[CFG_QUAD] = r.wr_cfg[CFG_QUAD];
        // one-time bits: a clear attempt fails and flags an error
        if (r.config_one[CFG_BOTTOM] && !r.wr_cfg[CFG_BOTTOM]) begin
          perr_set = 1'b1;
        end else if (!r.config_one[CFG_FREEZE]) begin
          n.config_one[CFG_BOTTOM] = r.wr_cfg[CFG_BOTTOM];
        end
        if (r.config_one[CFG_VOLATILE] && !r.wr_cfg[CFG_VOLATILE]) begin
          perr_set = 1'b1;
        end else begin
          n.config_one[CFG_VOLATILE] = r.wr_cfg[CFG_VOLATILE];
        end
        if (!r.config_one[CFG_FREEZE]) begin
          n.config_one[CFG_PARAM_PLACE] = r.config_one[CFG_PARAM_PLACE]
            | r.wr_cfg[CFG_PARAM_PLACE];
        end
        // freeze rides along in the same write and only sets here
        n.config_one[CFG_FREEZE] = r.config_one[CFG_FREEZE]
          | r.wr_cfg[CFG_FREEZE];
      end
    end
    // error flag: a new error wins over a clear in the same cycle
    n.status_one[ST1_PERR] = perr_set
      | (r.status_one[ST1_PERR] & ~clr_perr);

    // read-only suspend flags follow the controller; writes never reach
    n.suspend = SUSPEND_RESET;
    n.suspend[SUSP_ERASE] = i_erase_suspended;
    n.suspend[SUSP_PROG] = i_program_suspended;

    // quad mode: protect and hold pins act as data, seen as inactive
    n.wp_eff = r.config_one[CFG_QUAD] | r.wp_s2;
    n.hold_eff = r.config_one[CFG_QUAD] | r.hold_s2;

    // command reset keeps freeze, reloads volatile size bits
    if (soft_rst && r.config_one[CFG_VOLATILE]) begin
      n.status_one[ST1_SIZE_HI:ST1_SIZE_LO] = SIZE_VOLATILE_VALUE;
    end
    // hardware reset pin: clears freeze, abandons the frame
    if (hw_rst) begin
      n.config_one[CFG_FREEZE] = 1'b0;
      n.st = ST_CMD;
      n.bit_cnt = 3'h0;
      n.wr_cnt = 2'h0;
      n.so_oe = 1'b0;
      if (r.config_one[CFG_VOLATILE]) begin
        n.status_one[ST1_SIZE_HI:ST1_SIZE_LO] = SIZE_VOLATILE_VALUE;
      end
    end
    // power-on: config and size bits come from the build parameters, freeze and bit 4 forced clear
    if (i_rst) begin
      n = '0;
      n.sync1 = 3'h7;
      n.sync2 = 3'h7;
      n.sck_d = 1'b1;
      n.cs_n_d = 1'b1;
      n.rst_s1 = 1'b1;
      n.rst_s2 = 1'b1;
      // pins idle high, so no false active level follows reset
      n.wp_s1 = 1'b1;
      n.wp_s2 = 1'b1;
      n.hold_s1 = 1'b1;
      n.hold_s2 = 1'b1;
      n.st = ST_CMD;
      n.kind = RK_NONE;
      n.config_one = CONFIG_INIT;
      n.config_one[CFG_FREEZE] = 1'b0;
      n.config_one[4] = 1'b0;
      n.status_one = STATUS_ONE_RESET;
      n.status_one[ST1_SIZE_HI:ST1_SIZE_LO] =
        CONFIG_INIT[CFG_VOLATILE] ? SIZE_VOLATILE_VALUE : SIZE_INIT;
      n.wp_eff = 1'b1;
      n.hold_eff = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge i_ref_clk) begin
    r <= n;
  end

  // latency table lookup, registered inside
  latency_decode #(
    .ENHANCED(ENHANCED)
  ) u_latency (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_strobe(r.kind_stb),
    .i_kind(r.kind),
    .i_latency_select(r.config_one[CFG_LAT_HI:CFG_LAT_LO]),
    .o_latency(o_read_latency)
  );

  // outputs straight from the state register
  assign o_so = r.so;
  assign o_so_oe = r.so_oe;
  assign o_config_one = r.config_one;
  assign o_status_one = r.status_one;
  assign o_suspend_status = r.suspend;
  assign o_wp_n_eff = r.wp_eff;
  assign o_hold_n_eff = r.hold_eff;

  // checks: reset events seen by the checks
  logic any_reset;
  assign any_reset = hw_rst | soft_rst;

  sequence s_clear_bottom;
    commit && r.wr_cnt == WR_TWO_BYTES && r.config_one[CFG_BOTTOM]
      && !r.wr_cfg[CFG_BOTTOM];
  endsequence

  sequence s_clear_volatile;
    commit && r.wr_cnt == WR_TWO_BYTES && r.config_one[CFG_VOLATILE]
      && !r.wr_cfg[CFG_VOLATILE];
  endsequence

  AST_BOTTOM_CLEAR_ERR: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    s_clear_bottom |=> r.status_one[ST1_PERR] && r.config_one[CFG_BOTTOM])
    else $error("bottom bit clear not refused with error");

  AST_VOLATILE_CLEAR_ERR: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    s_clear_volatile |=> r.status_one[ST1_PERR]
      && r.config_one[CFG_VOLATILE])
    else $error("volatility bit clear not refused with error");

  AST_FREEZE_HOLDS: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    r.config_one[CFG_FREEZE] && !hw_rst |=> r.config_one[CFG_FREEZE])
    else $error("freeze dropped without hardware reset");

  AST_FREEZE_HW_CLEAR: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    hw_rst |=> !r.config_one[CFG_FREEZE])
    else $error("freeze survived hardware reset");

  AST_FREEZE_LOCKS: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    r.config_one[CFG_FREEZE] && !any_reset |=>
      $stable(r.status_one[ST1_SIZE_HI:ST1_SIZE_LO])
      && $stable(r.config_one[CFG_BOTTOM]))
    else $error("locked bits changed while frozen");

  AST_SIZE_RESET: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    any_reset && r.config_one[CFG_VOLATILE] |=>
      r.status_one[ST1_SIZE_HI:ST1_SIZE_LO] == SIZE_VOLATILE_VALUE)
    else $error("volatile size bits not forced to 111");

  AST_SUSPEND_FLAGS: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_suspend_status[SUSP_ERASE] == $past(i_erase_suspended)
      && o_suspend_status[SUSP_PROG] == $past(i_program_suspended))
    else $error("suspend flags do not follow controller");

  AST_SUSPEND_RSVD: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    o_suspend_status[7:2] == 6'h00)
    else $error("reserved suspend bits not zero");

  AST_QUAD_PINS: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    r.config_one[CFG_QUAD] [*2] |-> o_wp_n_eff && o_hold_n_eff)
    else $error("protect or hold active in quad mode");

  AST_LATENCY_UPDATE: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !r.kind_stb && !$past(r.kind_stb) |-> $stable(o_read_latency))
    else $error("latency changed without a read command");

endmodule
`default_nettype wire

// ---- src/flash_cfg_pkg.sv ----
// constants, enumerations and carriers shared by the flash config logic
package flash_cfg_pkg;

  // command codes seen on the serial link
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;

  // config_one field positions
  localparam int CFG_LAT_HI = 7;
  localparam int CFG_LAT_LO = 6;
  localparam int CFG_BOTTOM = 5;
  localparam int CFG_VOLATILE = 3;
  localparam int CFG_PARAM_PLACE = 2;
  localparam int CFG_QUAD = 1;
  localparam int CFG_FREEZE = 0;
  // status_one field positions
  localparam int ST1_PERR = 6;
  localparam int ST1_SIZE_HI = 4;
  localparam int ST1_SIZE_LO = 2;
  // suspend_status field positions
  localparam int SUSP_ERASE = 1;
  localparam int SUSP_PROG = 0;

  // values after reset, then bit and byte counter marks
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] SUSPEND_RESET = 8'h00;
  localparam logic [2:0] SIZE_VOLATILE_VALUE = 3'h7;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [1:0] WR_ONE_BYTE = 2'h1;
  localparam logic [1:0] WR_TWO_BYTES = 2'h2;

  // latency codes in table order
  localparam logic [1:0] LAT_11 = 2'h3;
  localparam logic [1:0] LAT_00 = 2'h0;
  localparam logic [1:0] LAT_01 = 2'h1;
  localparam logic [1:0] LAT_10 = 2'h2;

  // serial link state
  typedef enum logic [1:0] {
    ST_CMD,
    ST_WRITE,
    ST_READ,
    ST_IGNORE
  } spi_state_t;

  // read command families that carry a latency
  typedef enum logic [3:0] {
    RK_NONE,
    RK_PLAIN,
    RK_FAST,
    RK_DUAL_OUT,
    RK_QUAD_OUT,
    RK_DUAL_IO,
    RK_QUAD_IO,
    RK_DDR_FAST,
    RK_DDR_DUAL,
    RK_DDR_QUAD
  } read_kind_t;

  // mode and dummy cycle counts of one read
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] dummy;
  } latency_t;

  // serial link pins as seen from the device
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } spi_pins_t;

endpackage

// ---- src/latency_decode.sv ----
// registered decoder from latency code and read kind to cycle counts
`timescale 1ns/1ps
`default_nettype none
module latency_decode
  import flash_cfg_pkg::*;
#(
  parameter bit ENHANCED = 1'b0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // request
  input wire logic i_strobe,
  input wire read_kind_t i_kind,
  input wire logic [1:0] i_latency_select,
  // answer
  output logic [6:0] o_latency
);

  // one table entry picked by code 11, 00, 01, 10
  function automatic logic [3:0] pick(input logic [1:0] lc,
      input logic [3:0] d11, input logic [3:0] d00,
      input logic [3:0] d01, input logic [3:0] d10);
    logic [3:0] v;
    v = d10;
    case (lc)
      LAT_11: v = d11;
      LAT_00: v = d00;
      LAT_01: v = d01;
      default: v = d10;
    endcase
    return v;
  endfunction

  // full table; the variant is fixed at build time, never by software
  function automatic latency_t decode(input read_kind_t k,
      input logic [1:0] lc);
    latency_t l;
    logic [3:0] std_dummy;
    l = '0;
    std_dummy = (lc == LAT_11) ? 4'h0 : 4'h8;
    case (k)
      RK_PLAIN: l = '0;
      RK_FAST, RK_DUAL_OUT, RK_QUAD_OUT: l.dummy = std_dummy;
      RK_DUAL_IO: begin
        if (ENHANCED) begin
          l.mode = 3'h4;
          l.dummy = pick(lc, 4'h0, 4'h0, 4'h1, 4'h2);
        end else begin
          l.dummy = pick(lc, 4'h4, 4'h4, 4'h5, 4'h6);
        end
      end
      RK_QUAD_IO: begin
        l.mode = 3'h2;
        if (ENHANCED) begin
          l.dummy = pick(lc, 4'h1, 4'h4, 4'h4, 4'h5);
        end else begin
          l.dummy = pick(lc, 4'h1, 4'h4, 4'h4, 4'h5);
        end
      end
      RK_DDR_FAST: begin
        if (ENHANCED) begin
          l.mode = 3'h4;
          l.dummy = pick(lc, 4'h1, 4'h2, 4'h4, 4'h5);
        end else begin
          l.dummy = pick(lc, 4'h4, 4'h5, 4'h6, 4'h7);
        end
      end
      RK_DDR_DUAL: begin
        if (ENHANCED) begin
          l.mode = 3'h2;
          l.dummy = pick(lc, 4'h2, 4'h4, 4'h5, 4'h6);
        end else begin
          l.dummy = pick(lc, 4'h4, 4'h6, 4'h7, 4'h8);
        end
      end
      RK_DDR_QUAD: begin
        l.mode = 3'h1;
        l.dummy = pick(lc, 4'h3, 4'h6, 4'h7, 4'h8);
      end
      default: l = '0;
    endcase
    return l;
  endfunction

  latency_t lat_r;
  latency_t lat_nxt;

  // hold the counts of the last read command seen
  always_comb begin
    lat_nxt = lat_r;
    if (i_rst) begin
      lat_nxt = '0;
    end else if (i_strobe) begin
      lat_nxt = decode(i_kind, i_latency_select);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    lat_r <= lat_nxt;
  end

  assign o_latency = lat_r;

endmodule
`default_nettype wire

// ---- test/spi_host_model.sv ----
// host-side serial master that drives register frames into the device
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
  import flash_cfg_pkg::*;
(
  // device answer
  input wire logic i_so,
  // pins toward the device
  output var spi_pins_t o_spi
);
  localparam int HALF_NS = 24; // 48 ns link period, below 50 MHz
  // idle: deselected, link clock parked low between frames
  initial o_spi = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
  // one frame, msb first; so sampled at each rise, last byte kept
  task automatic frame(input logic [23:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    o_spi.cs_n <= 1'b0;
    #HALF_NS;
    for (int i = 0; i < nbits; i++) begin
      o_spi.si <= tx[23 - i];
      #HALF_NS;
      o_spi.sck <= 1'b1;
      rx = {rx[6:0], i_so};
      #HALF_NS;
      o_spi.sck <= 1'b0;
    end
    #HALF_NS;
    o_spi.cs_n <= 1'b1;
    // released data line flips so a stale bit never looks valid
    o_spi.si <= ~o_spi.si;
    // deselect gap well above two reference clocks
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the flash config, protection and status logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_cfg_pkg::*;
  logic i_ref_clk, i_rst, i_reset_pin_n, i_wp_n, i_hold_n;
  logic i_erase_suspended, i_program_suspended;
  spi_pins_t spi; // pins driven by the host model
  logic o_so, o_so_oe, wp_eff, hold_eff;
  logic [7:0] cfg, st1, susp, rd;
  logic [6:0] lat, lat_enh; // standard and enhanced variant counts
  int num_errors = 0;
  int total_checks = 0;
  // read commands in table order, latency codes in table order
  localparam logic [7:0] RD_CMDS [7] = '{8'h03, 8'h0B, 8'hBB, 8'hEB,
    8'h0D, 8'hBD, 8'hED};
  localparam logic [1:0] LC_ORDER [4] = '{LAT_11, LAT_00, LAT_01, LAT_10};
  // expected {mode, dummy}: upper hex digit mode, lower digit dummy
  localparam logic [6:0] EXP_HP [7][4] = '{'{7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h00, 7'h08, 7'h08, 7'h08}, '{7'h04, 7'h04, 7'h05, 7'h06},
    '{7'h21, 7'h24, 7'h24, 7'h25}, '{7'h04, 7'h05, 7'h06, 7'h07},
    '{7'h04, 7'h06, 7'h07, 7'h08}, '{7'h13, 7'h16, 7'h17, 7'h18}};
  localparam logic [6:0] EXP_EN [7][4] = '{'{7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h00, 7'h08, 7'h08, 7'h08}, '{7'h40, 7'h40, 7'h41, 7'h42},
    '{7'h21, 7'h24, 7'h24, 7'h25}, '{7'h41, 7'h42, 7'h44, 7'h45},
    '{7'h22, 7'h24, 7'h25, 7'h26}, '{7'h13, 7'h16, 7'h17, 7'h18}};

  // 200 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  spi_host_model host (.i_so(o_so), .o_spi(spi));

  flash_config_latency_status #(.ENHANCED(1'b0)) uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_spi(spi), .o_so(o_so),
    .o_so_oe(o_so_oe), .i_reset_pin_n(i_reset_pin_n), .i_wp_n(i_wp_n),
    .i_hold_n(i_hold_n), .i_erase_suspended(i_erase_suspended),
    .i_program_suspended(i_program_suspended), .o_config_one(cfg),
    .o_status_one(st1), .o_suspend_status(susp), .o_wp_n_eff(wp_eff),
    .o_hold_n_eff(hold_eff), .o_read_latency(lat));

  // second factory variant on the same pins, only its latency is watched
  flash_config_latency_status #(.ENHANCED(1'b1)) uut_enh (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_spi(spi), .o_so(),
    .o_so_oe(), .i_reset_pin_n(i_reset_pin_n), .i_wp_n(i_wp_n),
    .i_hold_n(i_hold_n), .i_erase_suspended(i_erase_suspended),
    .i_program_suspended(i_program_suspended), .o_config_one(),
    .o_status_one(), .o_suspend_status(), .o_wp_n_eff(),
    .o_hold_n_eff(), .o_read_latency(lat_enh));

  // register-sized compare
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // latency-count compare
  task automatic chk_lat(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write both registers, then let the sensed deselect take effect
  task automatic wr_regs(input logic [7:0] s, input logic [7:0] c);
    host.frame({CMD_WRITE_REGS, s, c}, 24, rd);
    repeat (10) @(posedge i_ref_clk);
  endtask
  // command byte then one answer byte
  task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] v);
    host.frame({cmd, 16'h0000}, 16, v);
  endtask
  // bare command byte
  task automatic cmd_only(input logic [7:0] cmd);
    host.frame({cmd, 16'h0000}, 8, rd);
    repeat (10) @(posedge i_ref_clk);
  endtask
  // side pins, changed on the rising edge
  task automatic set_pins(input logic wp, input logic hold,
                          input logic es, input logic ps);
    @(posedge i_ref_clk);
    i_wp_n <= wp;
    i_hold_n <= hold;
    i_erase_suspended <= es;
    i_program_suspended <= ps;
    repeat (6) @(posedge i_ref_clk);
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    num_errors++;
    $display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    i_rst = 1'b1;
    i_reset_pin_n = 1'b1;
    i_wp_n = 1'b1;
    i_hold_n = 1'b1;
    i_erase_suspended = 1'b0;
    i_program_suspended = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    // power-on values
    chk_reg(cfg, 8'h00);
    chk_reg(st1, 8'h00);
    chk_reg(susp, 8'h00);
    chk_reg({6'h00, wp_eff, hold_eff}, 8'h03);
    chk_lat(lat, 7'h00);
    $display("test reset done");
    // every combination of the two suspend flags, read back by 07h
    for (int k = 0; k < 4; k++) begin
      set_pins(1'b1, 1'b1, k[1], k[0]);
      rd_reg(CMD_READ_STATUS_TWO, rd);
      chk_reg(rd, {6'h00, k[1:0]});
      chk_reg(susp, {6'h00, k[1:0]});
    end
    set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test suspend done");
    // pins low: seen only while quad width is off
    wr_regs(8'h00, 8'h00);
    chk_reg({6'h00, wp_eff, hold_eff}, 8'h00);
    wr_regs(8'h00, 8'h02);
    chk_reg({6'h00, wp_eff, hold_eff}, 8'h03);
    $display("test quad done");
    // every latency code against every read family but dual and quad output, both variants
    for (int i = 0; i < 4; i++) begin
      wr_regs(8'h00, {LC_ORDER[i], 6'h02}); // quad set first
      // training pattern never enabled, so low-dummy codes are legal
      for (int j = 0; j < 7; j++) begin
        cmd_only(RD_CMDS[j]);
        chk_lat(lat, EXP_HP[j][i]);
        chk_lat(lat_enh, EXP_EN[j][i]);
      end
    end
    wr_regs(8'h00, 8'h00);
    set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test latency done");
    // one-time bits, set before any array work
    wr_regs(8'h08, 8'h20);
    chk_reg(cfg, 8'h20);
    wr_regs(8'h08, 8'h00);
    chk_reg(cfg, 8'h20);
    chk_reg(st1, 8'h48);
    cmd_only(CMD_CLEAR_STATUS);
    wr_regs(8'h08, 8'h28);
    cmd_only(CMD_SOFT_RESET);
    chk_reg(st1, 8'h1C);
    wr_regs(8'h1C, 8'h20);
    chk_reg(cfg, 8'h28);
    chk_reg(st1, 8'h5C);
    cmd_only(CMD_CLEAR_STATUS);
    $display("test one_time done");
    // freeze set in the same write, then locks size and placement
    wr_regs(8'h1C, 8'h29);
    chk_reg(cfg, 8'h29);
    chk_reg(st1 & 8'h1C, 8'h1C);
    wr_regs(8'h00, 8'hAD);
    chk_reg(cfg, 8'hA9);
    chk_reg(st1 & 8'h1C, 8'h1C);
    cmd_only(CMD_SOFT_RESET);
    chk_reg(cfg, 8'hA9);
    rd_reg(CMD_READ_CONFIG, rd);
    chk_reg(rd, 8'hA9);
    @(posedge i_ref_clk);
    i_reset_pin_n <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    i_reset_pin_n <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    chk_reg(cfg, 8'hA8);
    cmd_only(CMD_CLEAR_STATUS);
    rd_reg(CMD_READ_STATUS_ONE, rd);
    chk_reg(rd, 8'h1C);
    $display("test freeze done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
